//--- fsp_map.svh
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH

// register byte offsets
`define FSP_REG_STATUS    8'h00
`define FSP_REG_AE_OFFSET 8'h04
`define FSP_REG_AF_OFFSET 8'h08
`define FSP_REG_IRQ_STAT  8'h0C
`define FSP_REG_IRQ_MASK  8'h10

// status register fields
`define FSP_ST_EMPTY_N    0
`define FSP_ST_AEMPTY_N   1
`define FSP_ST_AFULL_N    2
`define FSP_ST_FULL_N     3
`define FSP_ST_DUAL_WE    4
`define FSP_ST_COUNT_LSB  16

// reset values
`define FSP_AE_OFFSET_RST 7
`define FSP_AF_OFFSET_RST 7
`define FSP_IRQ_MASK_RST  6'h00

// bus answers
`define FSP_RESP_OKAY     2'h0
`define FSP_RESP_SLVERR   2'h2

`endif

//--- fsp_pkg.sv
`default_nettype none
package fsp_pkg;

  // synchronised pin group
  typedef struct packed {
    logic prst_n;
    logic oe_n;
    logic rd_a_n;
    logic rd_b_n;
    logic wr_a_n;
    logic wr_b_ld;
  } fsp_pins_s;

  // sticky event bits, same layout in status and mask
  typedef struct packed {
    logic overflow;
    logic underflow;
    logic full;
    logic afull;
    logic aempty;
    logic empty;
  } fsp_irq_s;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } fsp_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fsp_axi_rsp_s;

  function automatic logic [31:0] fsp_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction

endpackage
`default_nettype wire

//--- fsp_fifo_read_flags.sv
// Overview of operation
// - both read enables low read one word per edge
// - reads ignored while empty flag low
// - output enable low drives output word
// - output enable high releases output word
// - empty flag low when no words stored
// - empty flag high when words stored, read side
// - almost-empty low within programmed empty offset
// - almost-empty offset defaults to seven
// - almost-empty updated on read clock
// - almost-full low within programmed full offset
// - almost-full offset defaults to seven
// - almost-full updated on write clock
// - full flag low when full, writes ignored
// - full flag high while space remains, write side
// - pointer reset clears pointers and sets flags
// - enabled write stores one word per edge
// - second-enable/load level at reset picks mode
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fsp_map.svh"
`default_nettype none
module fsp_fifo_read_flags
  import fsp_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 64
)
(
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // device pins
  input  wire fsp_pins_s    pins_in,
  input  wire logic [WIDTH-1:0] input_word_in,
  output logic [WIDTH-1:0]  output_word_out,
  output logic              output_word_oe_out,
  output logic              empty_flag_n_out,
  output logic              almost_empty_flag_n_out,
  output logic              almost_full_flag_n_out,
  output logic              full_flag_n_out,
  // register bus
  input  wire fsp_axi_req_s axi_req_in,
  output fsp_axi_rsp_s      axi_rsp_out,
  // interrupt
  output logic              irq_out
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 8 || (1 << AW) != DEPTH || WIDTH < 1 || WIDTH > 32 || CW > 16)
  begin : g_bad_params
    $error("fsp_fifo_read_flags: DEPTH must be a power of two from 8, WIDTH 1..32");
  end

  typedef struct packed {
    fsp_pins_s        p1;
    fsp_pins_s        p2;
    logic [WIDTH-1:0] d1;
    logic [WIDTH-1:0] d2;
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [CW-1:0]    cnt;
    logic             ef_n;
    logic             ae_n;
    logic             af_n;
    logic             ff_n;
    logic [WIDTH-1:0] q;
    logic             dual_we;
    logic [CW-1:0]    ae_off;
    logic [CW-1:0]    af_off;
    fsp_irq_s         ists;
    fsp_irq_s         imask;
    logic             aw_held;
    logic [7:0]       awaddr;
    logic             w_held;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } fsp_state_s;

  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  fsp_state_s       s_r;
  fsp_state_s       s_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic             rd_go;
  logic             wr_go;
  logic             rd_req;
  logic             wr_req;
  logic [CW-1:0]    cnt_nxt;
  fsp_irq_s         ev;
  fsp_irq_s         clr;
  logic             wr_do;
  logic             aw_hs;
  logic             w_hs;
  logic [31:0]      st_word;

  assign axi_rsp_out.awready = !s_r.aw_held && !s_r.bvalid;
  assign axi_rsp_out.wready  = !s_r.w_held && !s_r.bvalid;
  assign axi_rsp_out.bvalid  = s_r.bvalid;
  assign axi_rsp_out.bresp   = s_r.bresp;
  assign axi_rsp_out.arready = !s_r.rvalid;
  assign axi_rsp_out.rvalid  = s_r.rvalid;
  assign axi_rsp_out.rdata   = s_r.rdata;
  assign axi_rsp_out.rresp   = s_r.rresp;

  assign output_word_out         = s_r.q;
  // drive enable for the pad ring, which holds the actual three-state buffer
  assign output_word_oe_out      = !s_r.p2.oe_n;
  assign empty_flag_n_out        = s_r.ef_n;
  assign almost_empty_flag_n_out = s_r.ae_n;
  assign almost_full_flag_n_out  = s_r.af_n;
  assign full_flag_n_out         = s_r.ff_n;
  assign irq_out                 = |(s_r.ists & s_r.imask);

  always_comb
  begin
    s_nxt = s_r;
    // two-stage pin synchronisers
    s_nxt.p1 = pins_in;
    s_nxt.p2 = s_r.p1;
    s_nxt.d1 = input_word_in;
    s_nxt.d2 = s_r.d1;

    // one clock serves both sides, so the pointers need no crossing
    rd_req = !s_r.p2.rd_a_n && !s_r.p2.rd_b_n;
    wr_req = !s_r.p2.wr_a_n && s_r.p2.wr_b_ld;
    rd_go  = rd_req && s_r.ef_n && s_r.p2.prst_n;
    wr_go  = wr_req && s_r.ff_n && s_r.p2.prst_n;

    if (rd_go)
    begin
      s_nxt.q    = mem_r[s_r.rptr];
      s_nxt.rptr = s_r.rptr + AW'(1);
    end
    if (wr_go)
      s_nxt.wptr = s_r.wptr + AW'(1);

    cnt_nxt = s_r.cnt + CW'(wr_go) - CW'(rd_go);
    if (!s_r.p2.prst_n)
    begin
      s_nxt.wptr    = '0;
      s_nxt.rptr    = '0;
      cnt_nxt       = '0;
      s_nxt.dual_we = s_r.p2.wr_b_ld;
    end
    s_nxt.cnt  = cnt_nxt;
    s_nxt.ef_n = cnt_nxt != '0;
    s_nxt.ae_n = cnt_nxt > s_r.ae_off;
    s_nxt.af_n = (DEPTH_C - cnt_nxt) > s_r.af_off;
    s_nxt.ff_n = cnt_nxt != DEPTH_C;
    if (!s_r.p2.prst_n)
    begin
      s_nxt.ae_n = 1'b0;
      s_nxt.af_n = 1'b1;
    end

    // events on entry into each flag state, plus refused writes (overflow) and refused reads (underflow)
    ev.overflow  = wr_req && !s_r.ff_n && s_r.p2.prst_n;
    ev.underflow = rd_req && !s_r.ef_n && s_r.p2.prst_n;
    ev.full      = s_r.ff_n && !s_nxt.ff_n;
    ev.afull     = s_r.af_n && !s_nxt.af_n;
    ev.aempty    = s_r.ae_n && !s_nxt.ae_n;
    ev.empty     = s_r.ef_n && !s_nxt.ef_n;

    // write channel: address and data taken in either order
    aw_hs = axi_req_in.awvalid && !s_r.aw_held && !s_r.bvalid;
    w_hs  = axi_req_in.wvalid && !s_r.w_held && !s_r.bvalid;
    if (aw_hs)
    begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr  = axi_req_in.awaddr;
    end
    if (w_hs)
    begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata  = axi_req_in.wdata;
      s_nxt.wstrb  = axi_req_in.wstrb;
    end
    wr_do = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    clr   = '0;
    if (wr_do)
    begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = `FSP_RESP_OKAY;
      case (s_r.awaddr)
        `FSP_REG_STATUS:
          s_nxt.bresp = `FSP_RESP_OKAY;
        `FSP_REG_AE_OFFSET:
          if (!s_r.dual_we)
            s_nxt.ae_off = CW'(fsp_merge(32'(s_r.ae_off), s_r.wdata, s_r.wstrb));
          else
            s_nxt.bresp = `FSP_RESP_SLVERR;
        `FSP_REG_AF_OFFSET:
          if (!s_r.dual_we)
            s_nxt.af_off = CW'(fsp_merge(32'(s_r.af_off), s_r.wdata, s_r.wstrb));
          else
            s_nxt.bresp = `FSP_RESP_SLVERR;
        `FSP_REG_IRQ_STAT:
          clr = s_r.wstrb[0] ? fsp_irq_s'(s_r.wdata[5:0]) : '0;
        `FSP_REG_IRQ_MASK:
          if (s_r.wstrb[0])
            s_nxt.imask = fsp_irq_s'(s_r.wdata[5:0]);
        default:
          s_nxt.bresp = `FSP_RESP_SLVERR;
      endcase
    end
    if (s_r.bvalid && axi_req_in.bready)
      s_nxt.bvalid = 1'b0;
    // a new event wins over a clear in the same cycle
    s_nxt.ists = (s_r.ists & ~clr) | ev;

    // read channel
    st_word = '0;
    st_word[`FSP_ST_EMPTY_N]  = s_r.ef_n;
    st_word[`FSP_ST_AEMPTY_N] = s_r.ae_n;
    st_word[`FSP_ST_AFULL_N]  = s_r.af_n;
    st_word[`FSP_ST_FULL_N]   = s_r.ff_n;
    st_word[`FSP_ST_DUAL_WE]  = s_r.dual_we;
    st_word[`FSP_ST_COUNT_LSB +: CW] = s_r.cnt;
    if (s_r.rvalid && axi_req_in.rready)
      s_nxt.rvalid = 1'b0;
    if (axi_req_in.arvalid && !s_r.rvalid)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = `FSP_RESP_OKAY;
      case (axi_req_in.araddr)
        `FSP_REG_STATUS:    s_nxt.rdata = st_word;
        `FSP_REG_AE_OFFSET: s_nxt.rdata = 32'(s_r.ae_off);
        `FSP_REG_AF_OFFSET: s_nxt.rdata = 32'(s_r.af_off);
        `FSP_REG_IRQ_STAT:  s_nxt.rdata = 32'(s_r.ists);
        `FSP_REG_IRQ_MASK:  s_nxt.rdata = 32'(s_r.imask);
        default:
        begin
          s_nxt.rdata = '0;
          s_nxt.rresp = `FSP_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s_r         <= '0;
      s_r.p1      <= '1;
      s_r.p2      <= '1;
      s_r.af_n    <= 1'b1;
      s_r.ff_n    <= 1'b1;
      s_r.dual_we <= 1'b1;
      s_r.ae_off  <= CW'(`FSP_AE_OFFSET_RST);
      s_r.af_off  <= CW'(`FSP_AF_OFFSET_RST);
      s_r.imask   <= fsp_irq_s'(`FSP_IRQ_MASK_RST);
    end
    else
      s_r <= s_nxt;
  end

  // storage array, written only while the full flag allows it
  always_ff @(posedge clk_in)
  begin
    if (wr_go)
      mem_r[s_r.wptr] <= s_r.d2;
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  chk_read_advance: assert property (rd_req && s_r.ef_n && s_r.p2.prst_n |=>
    s_r.rptr == AW'($past(s_r.rptr) + AW'(1)))
    else $error("read pointer did not advance on an enabled read");
  chk_empty_block: assert property (rd_req && !s_r.ef_n |=>
    $stable(s_r.rptr) && $stable(s_r.q))
    else $error("read taken while empty");
  // pin checks look two edges back to span both synchroniser stages
  chk_oe_drive: assert property ((!rst_in && !pins_in.oe_n) [*3] |-> output_word_oe_out)
    else $error("output not driven with output enable low");
  chk_oe_release: assert property (pins_in.oe_n [*3] |-> !output_word_oe_out)
    else $error("output driven with output enable high");
  chk_empty_flag: assert property (empty_flag_n_out == ((s_r.wptr != s_r.rptr) || !full_flag_n_out))
    else $error("empty flag disagrees with pointers");
  chk_ae_level: assert property (s_r.p2.prst_n && $past(s_r.p2.prst_n) |->
    almost_empty_flag_n_out == (s_r.cnt > s_r.ae_off))
    else $error("almost-empty flag wrong");
  chk_af_level: assert property (s_r.p2.prst_n && $past(s_r.p2.prst_n) |->
    almost_full_flag_n_out == ((DEPTH_C - s_r.cnt) > s_r.af_off))
    else $error("almost-full flag wrong");
  chk_offset_default: assert property ($fell(rst_in) |->
    s_r.ae_off == CW'(`FSP_AE_OFFSET_RST) && s_r.af_off == CW'(`FSP_AF_OFFSET_RST))
    else $error("offsets not at default after reset");
  chk_full_block: assert property (wr_req && !s_r.ff_n |=> $stable(s_r.wptr))
    else $error("write taken while full");
  chk_ptr_reset: assert property (!s_r.p2.prst_n |=>
    s_r.cnt == '0 && !empty_flag_n_out && !almost_empty_flag_n_out && full_flag_n_out && almost_full_flag_n_out)
    else $error("pointer reset did not clear state");
  chk_strap_mode: assert property (!s_r.p2.prst_n |=> s_r.dual_we == $past(s_r.p2.wr_b_ld))
    else $error("mode not taken from strap");


  // full flag checked against the pointers and the empty flag; the flags themselves come from the counter
  chk_full_flag: assert property (full_flag_n_out == !((s_r.wptr == s_r.rptr) && empty_flag_n_out))
    else $error("full flag disagrees with pointers");
  chk_write_store: assert property (wr_req && full_flag_n_out && s_r.p2.prst_n |=>
    s_r.wptr == AW'($past(s_r.wptr) + AW'(1)))
    else $error("write pointer did not advance on an enabled write");
  chk_overflow_flag: assert property (wr_req && !full_flag_n_out && s_r.p2.prst_n |=>
    s_r.ists.overflow)
    else $error("refused write left no overflow mark");
  chk_underflow_flag: assert property (rd_req && !empty_flag_n_out && s_r.p2.prst_n |=>
    s_r.ists.underflow)
    else $error("refused read left no underflow mark");
  // output word stands until the next accepted read
  chk_word_hold: assert property (!(rd_req && empty_flag_n_out && s_r.p2.prst_n) |=>
    $stable(output_word_out))
    else $error("output word changed without a read");

  // register bus answers
  chk_write_answer: assert property (s_r.aw_held && s_r.w_held && !s_r.bvalid |=> axi_rsp_out.bvalid)
    else $error("write response missing");
  chk_offset_lock: assert property (s_r.aw_held && s_r.w_held && !s_r.bvalid && s_r.dual_we &&
    s_r.awaddr == `FSP_REG_AE_OFFSET |=> $stable(s_r.ae_off) && axi_rsp_out.bresp == `FSP_RESP_SLVERR)
    else $error("offset written in dual enable mode");
  chk_status_read: assert property (axi_req_in.arvalid && axi_rsp_out.arready &&
    axi_req_in.araddr == `FSP_REG_STATUS |=> axi_rsp_out.rvalid &&
    axi_rsp_out.rdata[`FSP_ST_EMPTY_N] == $past(empty_flag_n_out))
    else $error("status read does not show the empty flag");

  // main scenarios
  cov_read: cover property (rd_go ##1 rd_go);
  cov_full: cover property (!full_flag_n_out);
  cov_irq: cover property (irq_out);
  cov_underflow: cover property (rd_req && !empty_flag_n_out);
  cov_almost_full: cover property ($fell(almost_full_flag_n_out));

endmodule
`default_nettype wire

//--- fsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_host_model
  import fsp_pkg::*;
(
  // clock
  input  wire logic  clk_in,
  // device pins
  output fsp_pins_s  pins_out,
  output logic [8:0] word_out
);
  initial
  begin
    pins_out = 6'h2F;
    word_out = 9'h000;
  end

  // writes on consecutive edges; data line inverted once released
  task automatic push(input int n, input logic [8:0] base, input logic we_b = 1'b1);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_in);
      pins_out.wr_a_n  <= 1'b0;
      pins_out.wr_b_ld <= we_b;
      word_out         <= base + 9'(i);
    end
    @(posedge clk_in);
    pins_out.wr_a_n  <= 1'b1;
    pins_out.wr_b_ld <= 1'b1;
    word_out         <= ~word_out;
  endtask

  task automatic pop(input int n, input logic [1:0] en_n = 2'h0);
    @(posedge clk_in);
    pins_out.rd_a_n <= en_n[1];
    pins_out.rd_b_n <= en_n[0];
    repeat (n) @(posedge clk_in);
    pins_out.rd_a_n <= 1'b1;
    pins_out.rd_b_n <= 1'b1;
  endtask

  // mode level held across the whole pulse and one edge beyond
  task automatic preset(input logic mode);
    @(posedge clk_in);
    pins_out.wr_b_ld <= mode;
    pins_out.prst_n  <= 1'b0;
    repeat (2) @(posedge clk_in);
    pins_out.prst_n <= 1'b1;
    @(posedge clk_in);
    pins_out.wr_b_ld <= 1'b1;
  endtask

  task automatic set_oe(input logic v);
    @(posedge clk_in);
    pins_out.oe_n <= v;
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`include "fsp_map.svh"
`default_nettype none
module testbench
  import fsp_pkg::*;
;
  logic         clk_in;
  logic         rst_in;
  fsp_pins_s    pins;
  logic [8:0]   word;
  logic [8:0]   q;
  logic         oe;
  logic         ef;
  logic         aef;
  logic         aff;
  logic         ff;
  logic         irq;
  fsp_axi_req_s req;
  fsp_axi_rsp_s rsp;
  int           n_fail;
  int           n_compared;

  fsp_host_model host (.clk_in(clk_in), .pins_out(pins), .word_out(word));

  fsp_fifo_read_flags #(.WIDTH(9), .DEPTH(64)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .pins_in(pins), .input_word_in(word),
    .output_word_out(q), .output_word_oe_out(oe), .empty_flag_n_out(ef),
    .almost_empty_flag_n_out(aef), .almost_full_flag_n_out(aff), .full_flag_n_out(ff),
    .axi_req_in(req), .axi_rsp_out(rsp), .irq_out(irq));

  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic timeout;
    n_fail++;
    tally_and_finish();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge clk_in);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= s;
    req.bready  <= 1'b1;
    do
    begin
      @(posedge clk_in);
      t++;
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
    end
    while (rsp.bvalid !== 1'b1 && t < 100);
    req.bready <= 1'b0;
    r = rsp.bresp;
    if (rsp.bvalid !== 1'b1)
      timeout();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge clk_in);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do
    begin
      @(posedge clk_in);
      t++;
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
    end
    while (rsp.rvalid !== 1'b1 && t < 100);
    req.rready <= 1'b0;
    d = rsp.rdata;
    r = rsp.rresp;
    if (rsp.rvalid !== 1'b1)
      timeout();
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    cmp(d, e);
    cmp(32'(r), 32'(er));
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er,
                        input logic [3:0] s = 4'hF);
    logic [1:0] r;
    axi_wr(a, v, s, r);
    cmp(32'(r), 32'(er));
  endtask

  task automatic settle;
    repeat (4) @(posedge clk_in);
  endtask

  // flag pins and status word against the stored count
  task automatic check_state(input int n, input int ae);
    logic [31:0] d;
    logic [1:0]  r;
    logic [3:0]  e;
    e = {n != 64, 64 - n > 7, n > ae, n != 0};
    cmp(32'({ff, aff, aef, ef}), 32'(e));
    axi_rd(`FSP_REG_STATUS, d, r);
    cmp({d[31:16], 12'h000, d[3:0]}, {16'(n), 12'h000, e});
  endtask

  initial
  begin
    n_fail = 0;
    n_compared = 0;
    rst_in = 1'b1;
    req = '0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    check_state(0, 7);
    reg_rd(`FSP_REG_AE_OFFSET, 32'h7, `FSP_RESP_OKAY);
    reg_rd(`FSP_REG_AF_OFFSET, 32'h7, `FSP_RESP_OKAY);
    reg_rd(8'h40, 32'h0, `FSP_RESP_SLVERR);
    reg_wr(`FSP_REG_AE_OFFSET, 32'h3, `FSP_RESP_SLVERR);
    host.preset(1'b1);
    settle();
    reg_rd(`FSP_REG_STATUS, 32'h1C, `FSP_RESP_OKAY);
    cmp(32'(oe), 32'h1);
    host.set_oe(1'b1);
    host.pop(1);
    settle();
    cmp(32'(oe), 32'h0);
    cmp(32'(q), 32'h0);
    check_state(0, 7);
    host.set_oe(1'b0);
    host.push(1, 9'h0EE, 1'b0);
    settle();
    check_state(0, 7);
    for (int i = 1; i <= 8; i++)
    begin
      host.push(1, 9'(9'h100 + i));
      settle();
      check_state(i, 7);
    end
    host.push(48, 9'h109);
    settle();
    check_state(56, 7);
    host.push(1, 9'h139);
    settle();
    check_state(57, 7);
    host.push(7, 9'h13A);
    settle();
    check_state(64, 7);
    host.push(1, 9'h0AA);
    settle();
    check_state(64, 7);
    host.pop(1, 2'h1);
    settle();
    check_state(64, 7);
    host.pop(1, 2'h2);
    settle();
    check_state(64, 7);
    for (int k = 1; k <= 8; k++)
    begin
      host.pop(1);
      settle();
      cmp(32'(q), 32'(9'h100 + k));
    end
    host.pop(56);
    settle();
    check_state(0, 7);
    cmp(32'(q), 32'h140);
    host.pop(1);
    settle();
    cmp(32'(q), 32'h140);
    cmp(32'(irq), 32'h0);
    reg_rd(`FSP_REG_IRQ_STAT, 32'h3F, `FSP_RESP_OKAY);
    reg_wr(`FSP_REG_IRQ_MASK, 32'h20, `FSP_RESP_OKAY);
    cmp(32'(irq), 32'h1);
    reg_wr(`FSP_REG_IRQ_STAT, 32'h20, `FSP_RESP_OKAY);
    cmp(32'(irq), 32'h0);
    reg_rd(`FSP_REG_IRQ_STAT, 32'h1F, `FSP_RESP_OKAY);
    host.preset(1'b0);
    settle();
    reg_rd(`FSP_REG_STATUS, 32'h0C, `FSP_RESP_OKAY);
    reg_wr(`FSP_REG_AE_OFFSET, 32'h2, `FSP_RESP_OKAY);
    host.push(2, 9'h055);
    settle();
    check_state(2, 2);
    host.push(1, 9'h057);
    settle();
    check_state(3, 2);
    reg_wr(`FSP_REG_AE_OFFSET, 32'h55, `FSP_RESP_OKAY, 4'h2);
    reg_rd(`FSP_REG_AE_OFFSET, 32'h2, `FSP_RESP_OKAY);
    reg_wr(`FSP_REG_AF_OFFSET, 32'h3, `FSP_RESP_OKAY);
    reg_rd(`FSP_REG_AF_OFFSET, 32'h3, `FSP_RESP_OKAY);
    reg_rd(`FSP_REG_IRQ_MASK, 32'h20, `FSP_RESP_OKAY);
    tally_and_finish();
  end
endmodule
`default_nettype wire
